/* hdl/dpr_pkg.sv */
package dpr_pkg;

  // ----------------------------------------------------------------
  // array geometry
  // ----------------------------------------------------------------
  localparam int ROW_COUNT  = 512;
  localparam int ROW_BITS   = 36;
  localparam int ROW_AW     = 9;
  localparam int ADDR_W     = 14;
  localparam int LANE_BITS  = 9;
  localparam int LANE_COUNT = 4;
  localparam int DATA_PER_LANE = 8;

  // ----------------------------------------------------------------
  // port width in bits for each shape
  // ----------------------------------------------------------------
  localparam int WBITS_1  = 1;
  localparam int WBITS_2  = 2;
  localparam int WBITS_4  = 4;
  localparam int WBITS_9  = 9;
  localparam int WBITS_18 = 18;
  localparam int WBITS_36 = 36;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [35:0] DOUT_RST = 36'h0_0000_0000;

  // ----------------------------------------------------------------
  // enumerations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_SINGLE = 2'h0,
    MODE_TRUE   = 2'h1,
    MODE_PSEUDO = 2'h2,
    MODE_ROM    = 2'h3
  } dpr_mode_t;

  typedef enum logic [2:0] {
    W_16K_X1  = 3'h0,
    W_8K_X2   = 3'h1,
    W_4K_X4   = 3'h2,
    W_2K_X9   = 3'h3,
    W_1K_X18  = 3'h4,
    W_512_X36 = 3'h5
  } dpr_width_t;

  typedef enum logic [1:0] {
    WM_NORMAL  = 2'h0,
    WM_THROUGH = 2'h1,
    WM_RBW     = 2'h2
  } dpr_wmode_t;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    dpr_width_t width;
    dpr_wmode_t wmode;
    logic       out_reg;
  } dpr_port_cfg_t;

  typedef struct packed {
    logic        ce;
    logic        we;
    logic [3:0]  be;
    logic [13:0] addr;
    logic [35:0] din;
  } dpr_port_req_t;

endpackage

/* hdl/dpr_block_ram.sv */
// Overview of operation
// R1 - one 18 Kb array; each port has input and output registers
// R2 - shapes 16Kx1 to 1Kx18 everywhere; 512x36 not in true dual-port
// R3 - each port has its own clock enable over its registers
// R4 - a ninth bit per byte is stored for user parity checking
// R5 - per-byte write enables on 18-bit and 36-bit ports
// R6 - in multi-port modes ports may differ in width and depth
// R7 - bits run lsb to msb of word 0, then word 1, on every port
// R8 - array preloaded at configuration; writes off gives read-only memory
// R9 - address and write data registered before reaching the array
// R10 - optional output register after the read latch
// R11 - normal mode: output holds during a write
// R12 - write-through mode: written data appears on the output
// R13 - read-before-write shows old data; only x9, x18, x36
// R14 - latch reset selectable asynchronous or synchronous
// R15 - per-port latch reset clears only that port's latch
// R16 - global reset clears both latches
// R17 - fifo pointers and flags are built by outside logic
// R18 - clock enable low: no capture, no write, no output update
//
// Strobed register access and the address map were chosen for this implementation.
`timescale 1ns/100ps
module dpr_block_ram
(
  input  wire logic                   clock,
  input  wire logic                   rst_b,
  input  wire dpr_pkg::dpr_mode_t     cfg_mode,
  input  wire logic                   cfg_reset_async,
  input  wire dpr_pkg::dpr_port_cfg_t cfg_port_a,
  input  wire dpr_pkg::dpr_port_cfg_t cfg_port_b,
  input  wire logic                   load_en,
  input  wire logic [8:0]             load_addr,
  input  wire logic [35:0]            load_data,
  input  wire dpr_pkg::dpr_port_req_t port_a_req,
  input  wire logic                   port_a_latch_reset,
  output logic [35:0]                 port_a_dout,
  input  wire dpr_pkg::dpr_port_req_t port_b_req,
  input  wire logic                   port_b_latch_reset,
  output logic [35:0]                 port_b_dout
);

  // ----------------------------------------------------------------
  // address mapping
  // ----------------------------------------------------------------
  function automatic int width_bits(input dpr_pkg::dpr_width_t w);
    case (w)
      dpr_pkg::W_16K_X1:  return dpr_pkg::WBITS_1;
      dpr_pkg::W_8K_X2:   return dpr_pkg::WBITS_2;
      dpr_pkg::W_4K_X4:   return dpr_pkg::WBITS_4;
      dpr_pkg::W_2K_X9:   return dpr_pkg::WBITS_9;
      dpr_pkg::W_1K_X18:  return dpr_pkg::WBITS_18;
      default:            return dpr_pkg::WBITS_36;
    endcase
  endfunction

  function automatic logic [8:0] row_of(input dpr_pkg::dpr_width_t w,
                                        input logic [13:0] a);
    case (w)
      dpr_pkg::W_16K_X1:  return a[13:5];
      dpr_pkg::W_8K_X2:   return a[12:4];
      dpr_pkg::W_4K_X4:   return a[11:3];
      dpr_pkg::W_2K_X9:   return a[10:2];
      dpr_pkg::W_1K_X18:  return a[9:1];
      default:            return a[8:0];
    endcase
  endfunction

  // narrow shapes skip the parity bit of each lane, so x1..x4 words
  // cover only the 16 Kb of data bits
  function automatic logic [5:0] bit_pos(input dpr_pkg::dpr_width_t w,
                                         input logic [13:0] a,
                                         input int k);
    int d;
    int p;
    case (w)
      dpr_pkg::W_16K_X1:  d = int'(a[4:0]) + k;
      dpr_pkg::W_8K_X2:   d = int'(a[3:0]) * dpr_pkg::WBITS_2 + k;
      dpr_pkg::W_4K_X4:   d = int'(a[2:0]) * dpr_pkg::WBITS_4 + k;
      dpr_pkg::W_2K_X9:   d = int'(a[1:0]) * dpr_pkg::WBITS_9 + k;
      dpr_pkg::W_1K_X18:  d = int'(a[0]) * dpr_pkg::WBITS_18 + k;
      default:            d = k;
    endcase
    if (width_bits(w) < dpr_pkg::WBITS_9)
      p = (d / dpr_pkg::DATA_PER_LANE) * dpr_pkg::LANE_BITS + d % dpr_pkg::DATA_PER_LANE;
    else
      p = d;
    return p[5:0];
  endfunction

  function automatic logic [35:0] rd_word(input logic [35:0] row,
                                          input dpr_pkg::dpr_width_t w,
                                          input logic [13:0] a);
    logic [35:0] r;
    r = '0;
    for (int k = 0; k < dpr_pkg::ROW_BITS; k++)
    begin
      if (k < width_bits(w))
        r[k] = row[bit_pos(w, a, k)];                                 // R7
    end
    return r;
  endfunction

  function automatic logic [35:0] wr_row(input logic [35:0] row,
                                         input dpr_pkg::dpr_width_t w,
                                         input logic [13:0] a,
                                         input logic [35:0] din,
                                         input logic [3:0] be);
    logic [35:0] r;
    logic        lane_on;
    r = row;
    for (int k = 0; k < dpr_pkg::ROW_BITS; k++)
    begin
      lane_on = 1'b1;
      if (w == dpr_pkg::W_1K_X18 || w == dpr_pkg::W_512_X36)
        lane_on = be[k / dpr_pkg::LANE_BITS];                         // R5
      if (k < width_bits(w) && lane_on)
        r[bit_pos(w, a, k)] = din[k];                                 // R7
    end
    return r;
  endfunction

  function automatic logic [35:0] mask_w(input logic [35:0] v,
                                         input dpr_pkg::dpr_width_t w);
    logic [35:0] r;
    r = '0;
    for (int k = 0; k < dpr_pkg::ROW_BITS; k++)
    begin
      if (k < width_bits(w))
        r[k] = v[k];
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // effective configuration
  // ----------------------------------------------------------------
  // bit 1 grants reads and bit 0 writes; a refused direction is simply
  // dropped, so a stray strobe from the fabric cannot corrupt the array
  function automatic logic [1:0] port_perm(input dpr_pkg::dpr_mode_t m,
                                           input logic is_b);
    case (m)
      dpr_pkg::MODE_SINGLE:  return is_b ? 2'h0 : 2'h3;
      dpr_pkg::MODE_TRUE:    return 2'h3;
      dpr_pkg::MODE_PSEUDO:  return is_b ? 2'h2 : 2'h1;
      default:               return 2'h2;
    endcase
  endfunction

  dpr_pkg::dpr_width_t wid_a;
  dpr_pkg::dpr_width_t wid_b;
  logic                wr_a;
  logic                wr_b;
  logic                rd_a;
  logic                rd_b;
  logic [1:0]          perm_a;
  logic [1:0]          perm_b;

  always_comb
  begin
    wid_a = cfg_port_a.width;                                         // R6
    wid_b = cfg_port_b.width;                                         // R6
    // the widest shape needs both port paths, so in true dual-port mode it folds to x18 here
    if (cfg_mode == dpr_pkg::MODE_TRUE && wid_a == dpr_pkg::W_512_X36)
      wid_a = dpr_pkg::W_1K_X18;                                      // R2
    if (cfg_mode == dpr_pkg::MODE_TRUE && wid_b == dpr_pkg::W_512_X36)
      wid_b = dpr_pkg::W_1K_X18;                                      // R2
    perm_a = port_perm(cfg_mode, 1'b0);
    perm_b = port_perm(cfg_mode, 1'b1);
    wr_a = port_a_req.ce && port_a_req.we && perm_a[0];               // R8 R18
    wr_b = port_b_req.ce && port_b_req.we && perm_b[0];               // R3 R18
    rd_a = port_a_req.ce && perm_a[1];                                // R3 R18
    rd_b = port_b_req.ce && perm_b[1];                                // R3 R18
  end

  // ----------------------------------------------------------------
  // array
  // ----------------------------------------------------------------
  logic [35:0] mem [dpr_pkg::ROW_COUNT];                               // R1 R4
  logic [8:0]  row_a;
  logic [8:0]  row_b;
  logic [35:0] old_a;
  logic [35:0] old_b;
  logic [35:0] new_a;
  logic [35:0] new_b;

  always_comb
  begin
    row_a = row_of(wid_a, port_a_req.addr);
    row_b = row_of(wid_b, port_b_req.addr);
    old_a = mem[row_a];
    old_b = mem[row_b];
    new_a = wr_row(old_a, wid_a, port_a_req.addr, port_a_req.din, port_a_req.be);
    // port b lands on top of port a when both hit the same row
    if (wr_a && row_a == row_b)
      new_b = wr_row(new_a, wid_b, port_b_req.addr, port_b_req.din, port_b_req.be);
    else
      new_b = wr_row(old_b, wid_b, port_b_req.addr, port_b_req.din, port_b_req.be);
  end

  // array has no reset; contents come from the load port
  always_ff @(posedge clock)
  begin
    if (load_en)
      mem[load_addr] <= load_data;                                    // R8
    if (wr_a)
      mem[row_a] <= new_a;                                            // R9
    if (wr_b)
      mem[row_b] <= new_b;                                            // R9
  end

  // ----------------------------------------------------------------
  // output latches and output registers
  // ----------------------------------------------------------------
  logic [35:0] latch_a_r;
  logic [35:0] latch_a_nxt;
  logic [35:0] latch_b_r;
  logic [35:0] latch_b_nxt;
  logic [35:0] oreg_a_r;
  logic [35:0] oreg_a_nxt;
  logic [35:0] oreg_b_r;
  logic [35:0] oreg_b_nxt;

  function automatic logic [35:0] latch_next(input logic [35:0] cur,
                                             input logic rd,
                                             input logic wr,
                                             input dpr_pkg::dpr_wmode_t wm,
                                             input dpr_pkg::dpr_width_t w,
                                             input logic [35:0] old_row,
                                             input logic [13:0] a,
                                             input logic [35:0] din);
    logic [35:0] r;
    r = cur;
    if (wr)
    begin
      case (wm)
        dpr_pkg::WM_THROUGH: r = mask_w(din, w);                     // R12
        dpr_pkg::WM_RBW:
        begin
          // narrow shapes have no read-before-write; they act as normal
          if (width_bits(w) >= dpr_pkg::WBITS_9)
            r = rd_word(old_row, w, a);                              // R13
        end
        default: r = cur;                                            // R11
      endcase
    end
    else if (rd)
      r = rd_word(old_row, w, a);                                     // R11
    return r;
  endfunction

  always_comb
  begin
    latch_a_nxt = latch_next(latch_a_r, rd_a, wr_a, cfg_port_a.wmode, wid_a,
                             old_a, port_a_req.addr, port_a_req.din);
    latch_b_nxt = latch_next(latch_b_r, rd_b, wr_b, cfg_port_b.wmode, wid_b,
                             old_b, port_b_req.addr, port_b_req.din);
    oreg_a_nxt = port_a_req.ce ? latch_a_r : oreg_a_r;               // R10 R18
    oreg_b_nxt = port_b_req.ce ? latch_b_r : oreg_b_r;               // R10 R18
    // either latch reset clears only its own port, in both timing modes
    if (port_a_latch_reset)
    begin
      latch_a_nxt = dpr_pkg::DOUT_RST;                                // R14 R15
      oreg_a_nxt  = dpr_pkg::DOUT_RST;
    end
    if (port_b_latch_reset)
    begin
      latch_b_nxt = dpr_pkg::DOUT_RST;                                // R14 R15
      oreg_b_nxt  = dpr_pkg::DOUT_RST;
    end
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      latch_a_r <= dpr_pkg::DOUT_RST;                                 // R16
      latch_b_r <= dpr_pkg::DOUT_RST;                                 // R16
      oreg_a_r  <= dpr_pkg::DOUT_RST;
      oreg_b_r  <= dpr_pkg::DOUT_RST;
    end
    else
    begin
      latch_a_r <= latch_a_nxt;
      latch_b_r <= latch_b_nxt;
      oreg_a_r  <= oreg_a_nxt;
      oreg_b_r  <= oreg_b_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // asynchronous latch reset blanks the output at once; the flops clear
  // at the next edge, so the blanking costs a gate but no extra state
  always_comb
  begin
    port_a_dout = cfg_port_a.out_reg ? oreg_a_r : latch_a_r;          // R10
    port_b_dout = cfg_port_b.out_reg ? oreg_b_r : latch_b_r;          // R10
    if (cfg_reset_async && port_a_latch_reset)
      port_a_dout = dpr_pkg::DOUT_RST;                                // R14
    if (cfg_reset_async && port_b_latch_reset)
      port_b_dout = dpr_pkg::DOUT_RST;                                // R14
  end

endmodule

/* testbench/dpr_fabric.sv */
`timescale 1ns/100ps
module dpr_fabric
(
  input  wire logic              clock,
  output dpr_pkg::dpr_port_req_t req
);
  // ----------------------------------------------------------------
  // fabric side of one memory port
  // ----------------------------------------------------------------
  // no fifo pointers or flags live in the memory; fabric keeps them
  initial req = '0;

  // request stands for edges ce edges, then ce and we drop together
  task automatic xfer(input logic we, input logic [3:0] be, input logic [13:0] addr,
                      input logic [35:0] din, input int edges);
    @(posedge clock);
    req <= '{ce: 1'b1, we: we, be: be, addr: addr, din: din};
    repeat (edges) @(posedge clock);
    req <= '{ce: 1'b0, we: 1'b0, be: be, addr: ~addr, din: ~din};
  endtask
endmodule

/* testbench/dpr_block_ram_assertions.sv */
`timescale 1ns/100ps
module dpr_block_ram_assertions
(
  input wire logic                   clock,
  input wire logic                   rst_b,
  input wire dpr_pkg::dpr_mode_t     cfg_mode,
  input wire logic                   cfg_reset_async,
  input wire dpr_pkg::dpr_port_cfg_t cfg_port_a,
  input wire dpr_pkg::dpr_port_cfg_t cfg_port_b,
  input wire dpr_pkg::dpr_port_req_t port_a_req,
  input wire logic                   port_a_latch_reset,
  input wire logic [35:0]            port_a_dout,
  input wire dpr_pkg::dpr_port_req_t port_b_req,
  input wire logic                   port_b_latch_reset,
  input wire logic [35:0]            port_b_dout
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  a_release_clear: assert property ($rose(rst_b) |-> port_a_dout == 36'h0 && port_b_dout == 36'h0)
    else $error("dout not clear after reset");
  a_ce_hold_a: assert property ((!port_a_req.ce && !port_a_latch_reset) ##1 (!port_a_latch_reset
    && $stable(cfg_port_a) && $stable(cfg_mode)) |-> $stable(port_a_dout)) else $error("a moved, ce low");
  a_ce_hold_b: assert property ((!port_b_req.ce && !port_b_latch_reset) ##1 (!port_b_latch_reset
    && $stable(cfg_port_b) && $stable(cfg_mode)) |-> $stable(port_b_dout)) else $error("b moved, ce low");
  a_latch_clear_a: assert property (port_a_latch_reset |=> port_a_dout == 36'h0)
    else $error("a latch not cleared");
  a_latch_keep_b: assert property (port_a_latch_reset && !port_b_req.ce && !port_b_latch_reset
    |=> port_b_dout == $past(port_b_dout)) else $error("b hit by a latch reset");
  a_async_blank: assert property (cfg_reset_async && port_b_latch_reset |-> port_b_dout == 36'h0)
    else $error("b not blanked at once");
  a_through_echo: assert property (port_a_req.ce && port_a_req.we && !port_a_latch_reset
    && cfg_port_a.wmode == dpr_pkg::WM_THROUGH && cfg_port_a.width == dpr_pkg::W_512_X36
    && !cfg_port_a.out_reg && cfg_mode == dpr_pkg::MODE_SINGLE |=> port_a_dout == $past(port_a_req.din))
    else $error("write data not echoed");
  a_normal_hold: assert property (port_a_req.ce && port_a_req.we && !port_a_latch_reset
    && cfg_port_a.wmode == dpr_pkg::WM_NORMAL && !cfg_port_a.out_reg
    && cfg_mode != dpr_pkg::MODE_ROM |=> $stable(port_a_dout))
    else $error("dout moved on a normal write");

  c_out_reg: cover property (port_a_req.ce && cfg_port_a.out_reg);
  c_rom_read: cover property (port_b_req.ce && cfg_mode == dpr_pkg::MODE_ROM);
  c_async: cover property (cfg_reset_async && port_b_latch_reset);
endmodule

bind dpr_block_ram dpr_block_ram_assertions i_dpr_block_ram_assertions (.clock(clock), .rst_b(rst_b),
  .cfg_mode(cfg_mode), .cfg_reset_async(cfg_reset_async), .cfg_port_a(cfg_port_a),
  .cfg_port_b(cfg_port_b), .port_a_req(port_a_req), .port_a_latch_reset(port_a_latch_reset),
  .port_a_dout(port_a_dout), .port_b_req(port_b_req), .port_b_latch_reset(port_b_latch_reset),
  .port_b_dout(port_b_dout));

/* testbench/test_dpr_block_ram.sv */
`timescale 1ns/100ps
module test_dpr_block_ram;
  logic                   clock;
  logic                   rst_b;
  logic                   cfg_reset_async;
  logic                   load_en;
  logic [8:0]             load_addr;
  logic [35:0]            load_data;
  logic                   lr_a;
  logic                   lr_b;
  logic [35:0]            dout_a;
  logic [35:0]            dout_b;
  dpr_pkg::dpr_mode_t     mode;
  dpr_pkg::dpr_port_cfg_t cfg_a;
  dpr_pkg::dpr_port_cfg_t cfg_b;
  dpr_pkg::dpr_port_req_t req_a;
  dpr_pkg::dpr_port_req_t req_b;
  logic [35:0]            shadow [16];
  int                     mismatches;
  int                     num_checks;
  int                     cycles;
  `define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin mismatches++; \
    $display("Error %0t: got %h expected %h", $time, got, exp); end end

  dpr_fabric u_fab_a (.clock(clock), .req(req_a));
  dpr_fabric u_fab_b (.clock(clock), .req(req_b));
  dpr_block_ram i_dpr_block_ram (.clock(clock), .rst_b(rst_b), .cfg_mode(mode),
    .cfg_reset_async(cfg_reset_async), .cfg_port_a(cfg_a), .cfg_port_b(cfg_b),
    .load_en(load_en), .load_addr(load_addr), .load_data(load_data), .port_a_req(req_a),
    .port_a_latch_reset(lr_a), .port_a_dout(dout_a), .port_b_req(req_b),
    .port_b_latch_reset(lr_b), .port_b_dout(dout_b));

  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  function automatic logic [35:0] rnd36();
    logic [63:0] v;
    v = {$urandom(), $urandom()};
    return v[35:0] | 36'h1;
  endfunction

  // lane-wise merge, as the byte enables should apply it
  function automatic logic [35:0] merge(input logic [35:0] o, input logic [35:0] d,
                                        input logic [3:0] be);
    for (int i = 0; i < 4; i++)
      if (be[i]) o[i*9 +: 9] = d[i*9 +: 9];
    return o;
  endfunction

  task automatic setcfg(input dpr_pkg::dpr_mode_t m, input dpr_pkg::dpr_wmode_t wm,
                        input logic oreg);
    @(posedge clock);
    mode  <= m;
    cfg_a <= '{width: dpr_pkg::W_512_X36, wmode: wm, out_reg: oreg};
    cfg_b <= '{width: dpr_pkg::W_2K_X9, wmode: dpr_pkg::WM_NORMAL, out_reg: 1'b0};
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // run length is a few hundred cycles; the ceiling leaves wide margin
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      summarize();
    end
  end

  initial
  begin
    logic [35:0] d;
    logic [3:0]  be;
    int          n;
    rst_b = 1'b0;
    cfg_reset_async = 1'b0;
    load_en = 1'b0;
    load_addr = '0;
    load_data = '0;
    lr_a = 1'b0;
    lr_b = 1'b0;
    mode = dpr_pkg::MODE_SINGLE;
    cfg_a = '0;
    cfg_b = '0;
    mismatches = 0;
    num_checks = 0;
    cycles = 0;
    void'($urandom(95));
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    setcfg(dpr_pkg::MODE_ROM, dpr_pkg::WM_NORMAL, 1'b0);
    #1 `CHK(dout_a, 36'h0)
    for (n = 0; n < 16; n++)
    begin
      @(posedge clock);
      shadow[n] = rnd36();
      load_en <= 1'b1;
      load_addr <= 9'(n);
      load_data <= shadow[n];
    end
    @(posedge clock);
    load_en <= 1'b0;
    u_fab_a.xfer(1'b1, 4'hF, 14'h0, ~shadow[0], 1);
    for (n = 0; n < 16; n++)
    begin
      u_fab_a.xfer(1'b0, 4'h0, 14'(n), 36'h0, 1);
      #1 `CHK(dout_a, shadow[n])
    end
    for (n = 0; n < 64; n++)
    begin
      u_fab_b.xfer(1'b0, 4'h0, 14'(n), 36'h0, 1);
      #1 `CHK(dout_b, {27'h0, shadow[n/4][(n%4)*9 +: 9]})
    end
    $display("test preload and shapes done");
    setcfg(dpr_pkg::MODE_SINGLE, dpr_pkg::WM_NORMAL, 1'b0);
    for (int k = 0; k < 40; k++)
    begin
      n = int'($urandom_range(15));
      d = rnd36();
      be = (k == 0) ? 4'h0 : 4'($urandom());
      u_fab_a.xfer(1'b0, 4'h0, 14'(n), 36'h0, 1);
      u_fab_a.xfer(1'b1, be, 14'(n), d, 1);
      #1 `CHK(dout_a, shadow[n])
      shadow[n] = merge(shadow[n], d, be);
      u_fab_a.xfer(1'b0, 4'h0, 14'(n), 36'h0, 1);
      #1 `CHK(dout_a, shadow[n])
    end
    $display("test byte writes done");
    setcfg(dpr_pkg::MODE_SINGLE, dpr_pkg::WM_THROUGH, 1'b0);
    d = rnd36();
    u_fab_a.xfer(1'b1, 4'hF, 14'h3, d, 1);
    #1 `CHK(dout_a, d)
    shadow[3] = d;
    setcfg(dpr_pkg::MODE_SINGLE, dpr_pkg::WM_RBW, 1'b0);
    u_fab_a.xfer(1'b1, 4'hF, 14'h3, ~d, 1);
    #1 `CHK(dout_a, d)
    shadow[3] = ~d;
    $display("test write modes done");
    setcfg(dpr_pkg::MODE_SINGLE, dpr_pkg::WM_NORMAL, 1'b1);
    u_fab_a.xfer(1'b0, 4'h0, 14'h5, 36'h0, 2);
    #1 `CHK(dout_a, shadow[5])
    u_fab_a.xfer(1'b0, 4'h0, 14'h6, 36'h0, 1);
    #1 `CHK(dout_a, shadow[5])
    $display("test output register done");
    @(posedge clock);
    lr_a <= 1'b1;
    @(posedge clock);
    lr_a <= 1'b0;
    #1 `CHK(dout_a, 36'h0)
    `CHK(dout_b, {27'h0, shadow[15][35:27]})
    @(posedge clock);
    cfg_reset_async <= 1'b1;
    lr_b <= 1'b1;
    #1 `CHK(dout_b, 36'h0)
    @(posedge clock);
    lr_b <= 1'b0;
    setcfg(dpr_pkg::MODE_ROM, dpr_pkg::WM_NORMAL, 1'b0);
    u_fab_a.xfer(1'b0, 4'h0, 14'h7, 36'h0, 1);
    #1 `CHK(dout_a, shadow[7])
    u_fab_b.xfer(1'b0, 4'h0, 14'h1, 36'h0, 1);
    #1 `CHK(dout_b, {27'h0, shadow[0][17:9]})
    @(posedge clock);
    rst_b <= 1'b0;
    #1 `CHK({dout_a, dout_b}, 72'h0)
    @(posedge clock);
    rst_b <= 1'b1;
    $display("test resets done");
    setcfg(dpr_pkg::MODE_TRUE, dpr_pkg::WM_NORMAL, 1'b0);
    u_fab_a.xfer(1'b0, 4'h0, 14'h9, 36'h0, 1);
    #1 `CHK(dout_a, {18'h0, shadow[4][35:18]})
    d = rnd36();
    u_fab_b.xfer(1'b1, 4'h0, 14'h16, d, 1);
    #1 `CHK(dout_b, 36'h0)
    shadow[5][26:18] = d[8:0];
    u_fab_a.xfer(1'b0, 4'h0, 14'hB, 36'h0, 1);
    #1 `CHK(dout_a, {18'h0, shadow[5][35:18]})
    setcfg(dpr_pkg::MODE_PSEUDO, dpr_pkg::WM_NORMAL, 1'b0);
    d = rnd36();
    u_fab_a.xfer(1'b1, 4'hF, 14'h6, d, 1);
    #1 `CHK(dout_a, {18'h0, shadow[5][35:18]})
    shadow[6] = d;
    u_fab_b.xfer(1'b0, 4'h0, 14'h1B, 36'h0, 1);
    #1 `CHK(dout_b, {27'h0, shadow[6][35:27]})
    $display("test dual port modes done");
    summarize();
  end
endmodule
